// ---- logic/fault_group_if.sv ----
// eight open-drain group lines (fault line and error line per group, four groups)
// the converter end sits on group 0; peers are pulled by the bench through peer_*_oe
`timescale 1ns/100ps
interface fault_group_if;
	logic conv_ok_out;
	logic conv_ok_oe;
	logic conv_err_out;
	logic conv_err_oe;
	logic [3:0] mgr_ok_out;
	logic [3:0] mgr_ok_oe;
	logic [3:0] mgr_err_out;
	logic [3:0] mgr_err_oe;
	logic [3:0] peer_ok_oe;
	logic [3:0] peer_err_oe;
	logic [3:0] ok_level;
	logic [3:0] err_level;

	// wired-and with pull-up: any enabled driver pulls low
	assign ok_level = ~(mgr_ok_oe | peer_ok_oe | {3'h0, conv_ok_oe});
	assign err_level = ~(mgr_err_oe | peer_err_oe | {3'h0, conv_err_oe});

	modport converter (
		input ok_level,
		input err_level,
		output conv_ok_out,
		output conv_ok_oe,
		output conv_err_out,
		output conv_err_oe
	);

	modport manager (
		input ok_level,
		input err_level,
		output mgr_ok_out,
		output mgr_ok_oe,
		output mgr_err_out,
		output mgr_err_oe
	);
endinterface

// ---- logic/fault_prop_pkg.sv ----
// shared constants of the fault group link: config layout, timing, manager register map
// assumes a 100 MHz system clock on both ends
package fault_prop_pkg;

	// ----------------------------------------
	// converter propagation config register
	// ----------------------------------------
	localparam int CFG_W = 8;
	localparam logic [7:0] CFG_RESET = 8'h3f;
	localparam int CFG_HEAT_REPORT = 7;
	localparam int CFG_PG_REPORT = 6;
	// bits 5..0 gate propagation and line up with the cause bits below
	localparam int CAUSE_PHASE = 0;
	localparam int CAUSE_HIGH = 1;
	localparam int CAUSE_LOW = 2;
	localparam int CAUSE_CURR = 3;
	localparam int CAUSE_HEAT = 4;
	localparam int CAUSE_RAMP = 5;
	localparam int CAUSE_EXT = 6;
	localparam int CAUSE_W = 7;
	localparam logic [5:0] ERR_MASK = 6'h03;
	localparam logic [5:0] FAST_MASK = 6'h28;
	localparam logic [5:0] REG_MASK = 6'h14;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int HICCUP_MS = 130;
	localparam int HICCUP_CYCLES = HICCUP_MS * (CLK_HZ / 1000);
	localparam int HICCUP_CNT_W = 24;
	localparam int BLANK_W = 4;

	// ----------------------------------------
	// group limits
	// ----------------------------------------
	localparam int MAX_CONVERTERS = 32;
	localparam int GROUPS = 4;

	// ----------------------------------------
	// power manager registers
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] MGR_CTRL = 8'h00;
	localparam logic [7:0] MGR_ROUTE = 8'h04;
	localparam logic [7:0] MGR_STATUS = 8'h08;
	localparam logic [7:0] MGR_MASK = 8'h0c;
	localparam logic [7:0] MGR_LINES = 8'h10;
	localparam int CTRL_PROP_EN = 0;
	localparam int CTRL_FRONT_EN = 1;
	localparam int CTRL_CROWBAR_EN = 2;
	localparam int CTRL_RELEASE = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [15:0] ROUTE_RESET = 16'h0000;
	localparam logic [7:0] MASK_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_RUN = 3'b001,
		ST_REG_OFF = 3'b010,
		ST_FAST_OFF = 3'b011,
		ST_HICCUP = 3'b100
	} conv_state_t;

endpackage

// ---- logic/load_converter.sv ----
// converter end: propagation config, shutdown sequencing and hiccup/latch recovery
// assumes detectors, ramp engine and turn-on command run on sys_clk_i;
// group lines come from pins and are synchronised here
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
module load_converter #(
	parameter int HICCUP_CYCLES = fault_prop_pkg::HICCUP_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	fault_group_if.converter grp,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	input wire logic turn_on_i,
	input wire logic status_clear_i,
	input wire logic [5:0] latch_sel_i,
	input wire logic ramp_deviation_fault_i,
	input wire logic overheat_fault_i,
	input wire logic current_limit_fault_i,
	input wire logic low_output_fault_i,
	input wire logic high_output_error_i,
	input wire logic phase_error_i,
	input wire logic heat_warning_i,
	input wire logic output_window_flag_i,
	input wire logic output_zero_i,
	output logic power_en_o,
	output logic ramp_down_o,
	output logic fast_off_o,
	output logic low_side_on_o,
	output logic heat_report_o,
	output logic power_good_report_o,
	output logic [6:0] fault_cause_o
);
	// ----------------------------------------
	// config register
	// ----------------------------------------
	logic [7:0] propagation_config_reg;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			propagation_config_reg <= fault_prop_pkg::CFG_RESET;
		end else if (cfg_wr_i) begin
			propagation_config_reg <= cfg_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cfg_rdata_o <= 8'h00;
		end else begin
			cfg_rdata_o <= propagation_config_reg;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			heat_report_o <= 1'b0;
			power_good_report_o <= 1'b0;
		end else begin
			heat_report_o <= heat_warning_i & propagation_config_reg[fault_prop_pkg::CFG_HEAT_REPORT];
			power_good_report_o <= ~output_window_flag_i
				& propagation_config_reg[fault_prop_pkg::CFG_PG_REPORT];
		end
	end

	// ----------------------------------------
	// group line input
	// ----------------------------------------
	logic [1:0] line_pin;
	logic [1:0] line_s1;
	logic [1:0] line_s2;
	logic [1:0] line_s3;
	logic [1:0] line_filt;
	logic [1:0] line_drive;
	logic [1:0] line_low_ext;
	logic [fault_prop_pkg::BLANK_W-1:0] drive_hist [1:0];

	assign line_pin = {grp.err_level[0], grp.ok_level[0]};

	// three-stage sync, level counts when stages agree
	// own pull is blanked until the release has crossed the synchroniser,
	// otherwise a retry would see its own tail and shut down again
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_line
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					line_s1[gi] <= 1'b1;
					line_s2[gi] <= 1'b1;
					line_s3[gi] <= 1'b1;
					line_filt[gi] <= 1'b1;
					drive_hist[gi] <= '0;
				end else begin
					line_s1[gi] <= line_pin[gi];
					line_s2[gi] <= line_s1[gi];
					line_s3[gi] <= line_s2[gi];
					if (line_s2[gi] == line_s3[gi]) begin
						line_filt[gi] <= line_s3[gi];
					end
					drive_hist[gi] <= {drive_hist[gi][fault_prop_pkg::BLANK_W-2:0], line_drive[gi]};
				end
			end
			assign line_low_ext[gi] = ~line_filt[gi] & ~line_drive[gi] & ~|drive_hist[gi];
		end
	endgenerate

	// ----------------------------------------
	// fault causes
	// ----------------------------------------
	logic [5:0] fault_vec;
	logic new_err;
	logic new_fast;
	logic new_reg;
	logic ext_req;
	logic [6:0] cause_reg;
	logic [6:0] cause_next;
	logic cause_clear;

	assign fault_vec = {ramp_deviation_fault_i, overheat_fault_i, current_limit_fault_i,
		low_output_fault_i, high_output_error_i, phase_error_i};
	// fault type picks the turn-off kind
	assign new_err = |(fault_vec & fault_prop_pkg::ERR_MASK);
	assign new_fast = |(fault_vec & fault_prop_pkg::FAST_MASK);
	assign new_reg = |(fault_vec & fault_prop_pkg::REG_MASK);
	assign ext_req = line_low_ext[0] | line_low_ext[1];

	fault_prop_pkg::conv_state_t state_reg;
	fault_prop_pkg::conv_state_t state_next;

	// a cause arriving with the restart clear is dropped; causes gather only outside ST_OFF and ST_HICCUP
	always_comb begin
		cause_next = cause_clear ? 7'h00 : cause_reg;
		if (state_reg != fault_prop_pkg::ST_OFF && state_reg != fault_prop_pkg::ST_HICCUP) begin
			cause_next[5:0] = cause_next[5:0] | fault_vec;
			cause_next[fault_prop_pkg::CAUSE_EXT] = cause_next[fault_prop_pkg::CAUSE_EXT] | ext_req;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cause_reg <= 7'h00;
		end else begin
			cause_reg <= cause_next;
		end
	end

	// pull while an enabled cause is held
	// errors also pull the error line
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			line_drive <= 2'b00;
		end else begin
			line_drive[0] <= |(cause_next[5:0] & propagation_config_reg[5:0]);
			line_drive[1] <= |(cause_next[1:0] & propagation_config_reg[1:0]);
		end
	end

	// ----------------------------------------
	// hiccup timer and latch release
	// ----------------------------------------
	logic [fault_prop_pkg::HICCUP_CNT_W-1:0] hiccup_cnt;
	logic hiccup_done;
	logic on_low_seen;
	logic release_seen;
	logic latched;

	assign hiccup_done = (hiccup_cnt == HICCUP_CYCLES[fault_prop_pkg::HICCUP_CNT_W-1:0] - 1'b1);
	assign latched = |(cause_reg[5:0] & latch_sel_i);

	// count starts once the output is at zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			hiccup_cnt <= '0;
		end else if (state_reg != fault_prop_pkg::ST_HICCUP) begin
			hiccup_cnt <= '0;
		end else if (!hiccup_done) begin
			hiccup_cnt <= hiccup_cnt + 1'b1;
		end
	end

	// status clear or turn-on cycle releases a latch
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			on_low_seen <= 1'b0;
			release_seen <= 1'b0;
		end else if (state_reg != fault_prop_pkg::ST_HICCUP) begin
			on_low_seen <= 1'b0;
			release_seen <= 1'b0;
		end else begin
			if (!turn_on_i) begin
				on_low_seen <= 1'b1;
			end
			if (status_clear_i || (on_low_seen && turn_on_i)) begin
				release_seen <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// shutdown sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cause_clear = 1'b0;
		unique case (state_reg)
			fault_prop_pkg::ST_OFF: begin
				if (turn_on_i && !ext_req) begin
					state_next = fault_prop_pkg::ST_RUN;
				end
			end
			fault_prop_pkg::ST_RUN: begin
				// error on the line gives fast off
				// tracking and current limit go fast
				if (new_err || new_fast || line_low_ext[1]) begin
					state_next = fault_prop_pkg::ST_FAST_OFF;
				// low line turns this converter off
				end else if (new_reg || line_low_ext[0] || !turn_on_i) begin
					state_next = fault_prop_pkg::ST_REG_OFF;
				end
			end
			fault_prop_pkg::ST_REG_OFF: begin
				if (new_err || new_fast || line_low_ext[1]) begin
					state_next = fault_prop_pkg::ST_FAST_OFF;
				// ramp engine keeps delay and slew until zero
				end else if (output_zero_i) begin
					state_next = (|cause_next) ? fault_prop_pkg::ST_HICCUP : fault_prop_pkg::ST_OFF;
				end
			end
			fault_prop_pkg::ST_FAST_OFF: begin
				if (output_zero_i) begin
					state_next = fault_prop_pkg::ST_HICCUP;
				end
			end
			fault_prop_pkg::ST_HICCUP: begin
				// latching also needs the cause gone and a release
				if (hiccup_done && !ext_req && (!latched || (!(|fault_vec) && release_seen))) begin
					cause_clear = 1'b1;
					state_next = turn_on_i ? fault_prop_pkg::ST_RUN : fault_prop_pkg::ST_OFF;
				end
			end
			default: begin
				state_next = fault_prop_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= fault_prop_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// switch controls
	// ----------------------------------------
	// own error holds low side on
	// other faults keep the low side off
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			power_en_o <= 1'b0;
			ramp_down_o <= 1'b0;
			fast_off_o <= 1'b0;
			low_side_on_o <= 1'b0;
			fault_cause_o <= 7'h00;
		end else begin
			power_en_o <= (state_next == fault_prop_pkg::ST_RUN);
			ramp_down_o <= (state_next == fault_prop_pkg::ST_REG_OFF);
			fast_off_o <= (state_next == fault_prop_pkg::ST_FAST_OFF);
			low_side_on_o <= (state_next != fault_prop_pkg::ST_RUN) && (|cause_next[1:0]);
			fault_cause_o <= cause_next;
		end
	end

	// one open-drain pull per converter, line shared by up to 32
	assign grp.conv_ok_oe = line_drive[0];
	assign grp.conv_err_oe = line_drive[1];
	assign grp.conv_ok_out = 1'b0;
	assign grp.conv_err_out = 1'b0;

endmodule

// ---- logic/power_manager.sv ----
// manager end: watches the fault and error lines of four groups and passes shutdowns between groups
// assumes a plain register port on sys_clk_i; group lines come from pins
`timescale 1ns/100ps
module power_manager (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	fault_group_if.manager grp,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	output logic front_end_off_o,
	output logic crowbar_fire_o
);
	logic [3:0] ctrl_reg;
	logic [15:0] route_reg;
	logic [7:0] status_reg;
	logic [7:0] mask_reg;
	logic [3:0] ok_s1, ok_s2, ok_s3, ok_filt, ok_prev;
	logic [3:0] err_s1, err_s2, err_s3, err_filt, err_prev;
	logic [3:0] ok_drive, err_drive;
	logic [3:0] ok_low_ext, err_low_ext;
	logic [fault_prop_pkg::BLANK_W-1:0] ok_hist [3:0];
	logic [fault_prop_pkg::BLANK_W-1:0] err_hist [3:0];
	logic [7:0] events;

	// ----------------------------------------
	// per-group sync, blanking and routing
	// ----------------------------------------
	// four independent groups
	genvar g;
	generate
		for (g = 0; g < fault_prop_pkg::GROUPS; g++) begin : g_grp
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					{ok_s1[g], ok_s2[g], ok_s3[g], ok_filt[g], ok_prev[g]} <= 5'h1f;
					{err_s1[g], err_s2[g], err_s3[g], err_filt[g], err_prev[g]} <= 5'h1f;
					ok_hist[g] <= '0;
					err_hist[g] <= '0;
				end else begin
					{ok_s1[g], ok_s2[g], ok_s3[g]} <= {grp.ok_level[g], ok_s1[g], ok_s2[g]};
					{err_s1[g], err_s2[g], err_s3[g]} <= {grp.err_level[g], err_s1[g], err_s2[g]};
					if (ok_s2[g] == ok_s3[g]) begin
						ok_filt[g] <= ok_s3[g];
					end
					if (err_s2[g] == err_s3[g]) begin
						err_filt[g] <= err_s3[g];
					end
					ok_prev[g] <= ok_low_ext[g];
					err_prev[g] <= err_low_ext[g];
					ok_hist[g] <= {ok_hist[g][fault_prop_pkg::BLANK_W-2:0], ok_drive[g]};
					err_hist[g] <= {err_hist[g][fault_prop_pkg::BLANK_W-2:0], err_drive[g]};
				end
			end
			// own pulls are ignored so that routes cannot hold each other low
			assign ok_low_ext[g] = ~ok_filt[g] & ~ok_drive[g] & ~|ok_hist[g];
			assign err_low_ext[g] = ~err_filt[g] & ~err_drive[g] & ~|err_hist[g];
			// pull targets routed from any other low group
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					ok_drive[g] <= 1'b0;
					err_drive[g] <= 1'b0;
				end else begin
					ok_drive[g] <= ctrl_reg[fault_prop_pkg::CTRL_PROP_EN]
						& |(ok_low_ext & route_column(route_reg, g));
					err_drive[g] <= ctrl_reg[fault_prop_pkg::CTRL_PROP_EN]
						& |(err_low_ext & route_column(route_reg, g));
				end
			end
			assign events[g] = ~ok_prev[g] & ok_low_ext[g];
			assign events[g + 4] = ~err_prev[g] & err_low_ext[g];
		end
	endgenerate

	// bit t of each source nibble; a group never routes to itself
	function automatic logic [3:0] route_column(input logic [15:0] r, input int t);
		logic [3:0] c;
		c = 4'h0;
		for (int s = 0; s < 4; s++) begin
			c[s] = (s != t) & r[s * 4 + t];
		end
		return c;
	endfunction

	assign grp.mgr_ok_oe = ok_drive;
	assign grp.mgr_err_oe = err_drive;
	assign grp.mgr_ok_out = 4'h0;
	assign grp.mgr_err_out = 4'h0;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl_reg <= fault_prop_pkg::CTRL_RESET;
			route_reg <= fault_prop_pkg::ROUTE_RESET;
			mask_reg <= fault_prop_pkg::MASK_RESET;
		end else if (wr_i) begin
			if (addr_i == fault_prop_pkg::MGR_CTRL) begin
				ctrl_reg <= {1'b0, wdata_i[2:0]};
			end
			if (addr_i == fault_prop_pkg::MGR_ROUTE) begin
				route_reg <= wdata_i[15:0];
			end
			if (addr_i == fault_prop_pkg::MGR_MASK) begin
				mask_reg <= wdata_i[7:0];
			end
		end
	end

	// sticky events; a new event beats a write-one clear
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			status_reg <= 8'h00;
		end else begin
			status_reg <= (status_reg & ~((wr_i && addr_i == fault_prop_pkg::MGR_STATUS)
				? wdata_i[7:0] : 8'h00)) | events;
		end
	end

	// error shuts front end and fires crowbar until released
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			front_end_off_o <= 1'b0;
			crowbar_fire_o <= 1'b0;
		end else if (|err_low_ext) begin
			front_end_off_o <= front_end_off_o | ctrl_reg[fault_prop_pkg::CTRL_FRONT_EN];
			crowbar_fire_o <= crowbar_fire_o | ctrl_reg[fault_prop_pkg::CTRL_CROWBAR_EN];
		end else if (wr_i && addr_i == fault_prop_pkg::MGR_CTRL
			&& wdata_i[fault_prop_pkg::CTRL_RELEASE]) begin
			front_end_off_o <= 1'b0;
			crowbar_fire_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_reg & mask_reg);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			unique case (addr_i)
				fault_prop_pkg::MGR_CTRL: rdata_o <= {28'h0, ctrl_reg};
				fault_prop_pkg::MGR_ROUTE: rdata_o <= {16'h0, route_reg};
				fault_prop_pkg::MGR_STATUS: rdata_o <= {24'h0, status_reg};
				fault_prop_pkg::MGR_MASK: rdata_o <= {24'h0, mask_reg};
				fault_prop_pkg::MGR_LINES: rdata_o <= {14'h0, crowbar_fire_o, front_end_off_o,
					err_drive, ok_drive, err_filt, ok_filt};
				default: rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

endmodule

// ---- verif/fault_group_monitor.sv ----
// assertions on the group lines between the converter end and the manager end
// assumes one clock and a synchronous active-high reset shared by both ends
`timescale 1ns/100ps
module fault_group_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic conv_ok_out,
	input wire logic conv_ok_oe,
	input wire logic conv_err_out,
	input wire logic conv_err_oe,
	input wire logic [3:0] mgr_ok_out,
	input wire logic [3:0] mgr_ok_oe,
	input wire logic [3:0] mgr_err_out,
	input wire logic [3:0] mgr_err_oe,
	input wire logic [3:0] peer_ok_oe,
	input wire logic [3:0] peer_err_oe
);
	// ----------------------------------------
	// cycles since any pull other than the manager's own
	// ----------------------------------------
	logic ext_pull;
	logic [4:0] quiet_reg;
	assign ext_pull = |{peer_ok_oe, peer_err_oe, conv_ok_oe, conv_err_oe};
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || ext_pull) begin
			quiet_reg <= 5'h00;
		end else if (quiet_reg != 5'h1f) begin
			quiet_reg <= quiet_reg + 5'h01;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// the manager needs a few cycles of filtering, so a cause may lie some cycles back
	sequence ext_recent;
		quiet_reg < 5'h0a;
	endsequence
	sequence ext_gone;
		quiet_reg == 5'h10;
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	conv_ok_pull_a: assert property (conv_ok_oe |-> !conv_ok_out)
		else $error("converter drives its fault line high");
	conv_err_pull_a: assert property (conv_err_oe |-> !conv_err_out)
		else $error("converter drives its error line high");
	mgr_ok_pull_a: assert property ((mgr_ok_oe & mgr_ok_out) == 4'h0)
		else $error("manager drives a fault line high");
	mgr_err_pull_a: assert property ((mgr_err_oe & mgr_err_out) == 4'h0)
		else $error("manager drives an error line high");
	mgr_ok_cause_a: assert property ($rose(|mgr_ok_oe) |-> ext_recent)
		else $error("manager pulls a fault line with no outside cause");
	mgr_err_cause_a: assert property ($rose(|mgr_err_oe) |-> ext_recent)
		else $error("manager pulls an error line with no outside cause");
	mgr_release_a: assert property (ext_gone |-> (mgr_ok_oe | mgr_err_oe) == 4'h0)
		else $error("manager keeps pulling after all causes left");
	reset_idle_a: assert property (disable iff (1'b0) $fell(rst_i) |->
		!conv_ok_oe && !conv_err_oe && (mgr_ok_oe | mgr_err_oe) == 4'h0)
		else $error("a line is pulled right after reset");
endmodule

// ---- verif/tb_top.sv ----
// bench: converter and manager joined over the group lines, checked at their user ports and at their line pulls
// assumes the package and the group interface are compiled before it
`timescale 1ns/100ps
module tb_top;
	localparam int HC = 20;
	localparam logic [5:0] FAST_M = fault_prop_pkg::ERR_MASK | fault_prop_pkg::FAST_MASK;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_wr = 1'b0;
	logic turn_on = 1'b0;
	logic status_clear = 1'b0;
	logic heat_warn = 1'b0;
	logic win_flag = 1'b1;
	logic out_zero = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] cfg_wdata = 8'h00;
	logic [7:0] addr = 8'h00;
	logic [5:0] latch_sel = 6'h00;
	logic [5:0] flt = 6'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [7:0] cfg_rdata;
	logic [6:0] cause;
	logic [31:0] rdata;
	logic power_en, ramp_down, fast_off, low_side, heat_rep, pg_rep, irq, front_off, crowbar;
	int err_count = 0;
	int checked = 0;
	int k;

	fault_group_if grp ();
	load_converter #(.HICCUP_CYCLES(HC)) u_load_converter (
		.sys_clk_i(sys_clk), .rst_i(rst), .grp(grp.converter), .cfg_wr_i(cfg_wr),
		.cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .turn_on_i(turn_on),
		.status_clear_i(status_clear), .latch_sel_i(latch_sel),
		.ramp_deviation_fault_i(flt[5]), .overheat_fault_i(flt[4]),
		.current_limit_fault_i(flt[3]), .low_output_fault_i(flt[2]),
		.high_output_error_i(flt[1]), .phase_error_i(flt[0]), .heat_warning_i(heat_warn),
		.output_window_flag_i(win_flag), .output_zero_i(out_zero), .power_en_o(power_en),
		.ramp_down_o(ramp_down), .fast_off_o(fast_off), .low_side_on_o(low_side),
		.heat_report_o(heat_rep), .power_good_report_o(pg_rep), .fault_cause_o(cause)
	);
	power_manager u_power_manager (
		.sys_clk_i(sys_clk), .rst_i(rst), .grp(grp.manager), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .front_end_off_o(front_off),
		.crowbar_fire_o(crowbar)
	);
	fault_group_monitor u_fault_group_monitor (
		.sys_clk_i(sys_clk), .rst_i(rst), .conv_ok_out(grp.conv_ok_out),
		.conv_ok_oe(grp.conv_ok_oe), .conv_err_out(grp.conv_err_out),
		.conv_err_oe(grp.conv_err_oe), .mgr_ok_out(grp.mgr_ok_out), .mgr_ok_oe(grp.mgr_ok_oe),
		.mgr_err_out(grp.mgr_err_out), .mgr_err_oe(grp.mgr_err_oe),
		.peer_ok_oe(grp.peer_ok_oe), .peer_err_oe(grp.peer_err_oe)
	);

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic close_out;
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic settle;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic restart;
		@(posedge sys_clk);
		rst <= 1'b1;
		turn_on <= 1'b0;
		flt <= 6'h00;
		out_zero <= 1'b0;
		latch_sel <= 6'h00;
		grp.peer_ok_oe <= 4'h0;
		grp.peer_err_oe <= 4'h0;
		tick(2);
		rst <= 1'b0;
	endtask
	task automatic cfg_w(input logic [7:0] d);
		cfg_wr <= 1'b1;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
	endtask
	task automatic run_up;
		turn_on <= 1'b1;
		for (k = 0; k < 20 && power_en !== 1'b1; k++) settle();
		chk("power_en", 1, power_en);
		@(posedge sys_clk);
	endtask
	task automatic mwr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic mrd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		chk(nm, exp, rdata);
	endtask

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// a full run takes about 900 cycles
	initial begin
		tick(20000);
		err_count++;
		close_out();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		grp.peer_ok_oe = 4'h0;
		grp.peer_err_oe = 4'h0;
		tick(20);
		rst <= 1'b0;
		settle();
		chk("cfg_reset", 8'h3f, cfg_rdata);
		@(posedge sys_clk);
		heat_warn <= 1'b1;
		win_flag <= 1'b0;
		cfg_w(8'hc0);
		settle();
		chk("cfg_back", 8'hc0, cfg_rdata);
		chk("heat_report", 1, heat_rep);
		chk("pg_report", 1, pg_rep);
		restart();
		settle();
		chk("reports_off", 0, {heat_rep, pg_rep});
		// every own cause, with propagation on and then off
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 6; i++) begin
				restart();
				cfg_w(c ? 8'h00 : 8'h3f);
				run_up();
				flt[i] <= 1'b1;
				tick(HC);
				#1;
				chk("fast_off", FAST_M[i], fast_off);
				chk("ramp_down", fault_prop_pkg::REG_MASK[i], ramp_down);
				chk("low_side", fault_prop_pkg::ERR_MASK[i], low_side);
				chk("cause", 7'h01 << i, cause);
				chk("err_pull", fault_prop_pkg::ERR_MASK[i] && c == 0, grp.conv_err_oe);
				if (i > 1) chk("ok_pull", c == 0, grp.conv_ok_oe);
				@(posedge sys_clk);
				flt <= 6'h00;
				out_zero <= 1'b1;
				for (k = 0; k < HC + 20 && power_en !== 1'b1; k++) settle();
				chk("retry_gap", 1, k >= HC && k <= HC + 4);
				chk("pull_free", 0, grp.conv_ok_oe | grp.conv_err_oe);
			end
		end
		restart();
		latch_sel <= 6'h10;
		run_up();
		flt[4] <= 1'b1;
		tick(3);
		flt <= 6'h00;
		out_zero <= 1'b1;
		tick(HC + 10);
		settle();
		chk("latched_off", 0, power_en);
		@(posedge sys_clk);
		status_clear <= 1'b1;
		@(posedge sys_clk);
		status_clear <= 1'b0;
		for (k = 0; k < HC + 10 && power_en !== 1'b1; k++) settle();
		chk("latch_clear", 1, power_en);
		// a peer holds the fault line, then the error line
		for (int j = 0; j < 2; j++) begin
			restart();
			run_up();
			grp.peer_ok_oe <= {3'h0, j == 0};
			grp.peer_err_oe <= {3'h0, j == 1};
			tick(8);
			settle();
			chk("peer_ramp", j == 0, ramp_down);
			chk("peer_fast", j == 1, fast_off);
			chk("ext_cause", 1, cause[6]);
			@(posedge sys_clk);
			out_zero <= 1'b1;
			tick(HC + 10);
			settle();
			chk("held_off", 0, power_en);
			@(posedge sys_clk);
			grp.peer_ok_oe <= 4'h0;
			grp.peer_err_oe <= 4'h0;
			for (k = 0; k < HC + 20 && power_en !== 1'b1; k++) settle();
			chk("line_freed", 1, power_en);
		end
		// manager: registers, routing, interrupt, front end and crowbar
		restart();
		run_up();
		mrd("ctrl_rst", fault_prop_pkg::MGR_CTRL, 0);
		mrd("route_rst", fault_prop_pkg::MGR_ROUTE, 0);
		mrd("mask_rst", fault_prop_pkg::MGR_MASK, 0);
		mwr(fault_prop_pkg::MGR_CTRL, 32'h7);
		mwr(fault_prop_pkg::MGR_ROUTE, 32'h50);
		mwr(fault_prop_pkg::MGR_MASK, 32'hff);
		mwr(8'h20, 32'hffffffff);
		mrd("unmapped", 8'h20, 0);
		mrd("route", fault_prop_pkg::MGR_ROUTE, 32'h50);
		@(posedge sys_clk);
		grp.peer_ok_oe <= 4'h2;
		tick(16);
		settle();
		chk("routed_pull", 4'h5, grp.mgr_ok_oe);
		chk("irq_on", 1, irq);
		chk("group_off", 1, ramp_down);
		mrd("status", fault_prop_pkg::MGR_STATUS, 32'h2);
		mrd("lines", fault_prop_pkg::MGR_LINES, 32'h5f8);
		@(posedge sys_clk);
		grp.peer_ok_oe <= 4'h0;
		tick(12);
		mwr(fault_prop_pkg::MGR_STATUS, 32'hff);
		settle();
		chk("released", 0, grp.mgr_ok_oe);
		mrd("status_clr", fault_prop_pkg::MGR_STATUS, 0);
		chk("irq_off", 0, irq);
		mwr(fault_prop_pkg::MGR_MASK, 32'h0);
		mwr(fault_prop_pkg::MGR_CTRL, 32'h6);
		@(posedge sys_clk);
		grp.peer_ok_oe <= 4'h8;
		grp.peer_err_oe <= 4'h8;
		tick(12);
		settle();
		chk("no_prop", 0, grp.mgr_ok_oe);
		chk("masked", 0, irq);
		chk("front_off", 1, front_off);
		chk("crowbar", 1, crowbar);
		mrd("status_m", fault_prop_pkg::MGR_STATUS, 32'h88);
		@(posedge sys_clk);
		grp.peer_ok_oe <= 4'h0;
		grp.peer_err_oe <= 4'h0;
		tick(8);
		settle();
		chk("front_hold", 1, front_off & crowbar);
		mwr(fault_prop_pkg::MGR_CTRL, 32'h8);
		settle();
		settle();
		chk("front_rel", 0, front_off | crowbar);
		close_out();
	end
endmodule
